//--- rtl/dsacc_map.svh
// Address map, field positions and constants of the data-space access block
`ifndef DSACC_MAP_SVH
`define DSACC_MAP_SVH
`define DSACC_AW 16
`define DSACC_DW 16
`define DSACC_WIN_BIT 15
`define DSACC_RAM_BASE 16'h1000
`define DSACC_RAM_WORDS 8192
`define DSACC_RAM_IW 13
`define DSACC_SFR_LAST 16'h0fff
`define DSACC_NEAR_LAST 16'h1fff
`define DSACC_WREG_BASE 16'h0000
`define DSACC_DSP_ACCUMULATOR_A_BASE 16'h0020
`define DSACC_DSP_ACCUMULATOR_B_BASE 16'h0026
`define DSACC_PC_LO 16'h002e
`define DSACC_PC_HI 16'h0030
`define DSACC_LSTART_LO 16'h0032
`define DSACC_LSTART_HI 16'h0034
`define DSACC_INTERRUPT_CONTROL_ONE 16'h0036
`define DSACC_ADDRESS_FAULT_FLAG_BIT 3
`define DSACC_NCTX 5
`define DSACC_NWREG 16
`define DSACC_STEP_BYTE 16'h0001
`define DSACC_STEP_WORD 16'h0002
`define DSACC_ZERO16 16'h0000
`endif

//--- rtl/dsacc_pkg.sv
// Types shared by the data-space access block
package dsacc_pkg;
   typedef enum logic [1:0] {
      DSACC_REG_IDLE = 2'b01,
      DSACC_REG_FAULT = 2'b10
   } dsacc_fault_t;
   typedef enum logic [1:0] {
      DSACC_EXT_NONE = 2'b00,
      DSACC_EXT_SIGN = 2'b01,
      DSACC_EXT_ZERO = 2'b10
   } dsacc_ext_t;
endpackage

//--- rtl/dsacc_top.sv
// Data-space access: decode, byte lanes, fault trap and mapped core registers
`include "dsacc_map.svh"
module dsacc_top
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic rd_en,
   input wire logic [15:0] rd_addr,
   input wire logic rd_byte,
   input wire logic rd_post_inc,
   input wire logic rd_near,
   input wire logic [12:0] rd_near_addr,
   output logic [15:0] rd_data,
   output logic rd_valid,
   output logic [15:0] rd_next_addr,
   output logic rd_window,
   input wire logic wr_en,
   input wire logic [15:0] wr_addr,
   input wire logic wr_byte,
   input wire logic wr_post_inc,
   input wire logic [15:0] wr_data,
   output logic [15:0] wr_next_addr,
   input wire logic wreg_load,
   input wire logic [3:0] wreg_sel,
   input wire logic [1:0] wreg_op,
   input wire logic [7:0] wreg_byte,
   input wire logic [2:0] ctx_sel,
   input wire logic [22:0] pc_in,
   input wire logic [22:0] loop_start_in,
   input wire logic [39:0] acc_a_in,
   input wire logic [39:0] acc_b_in,
   input wire logic acc_load,
   input wire logic fault_clear,
   output logic [15:0] wreg_rd_data,
   output logic address_fault_flag,
   output logic trap_req,
   output logic [22:0] pc_out
);
   localparam int NALT = `DSACC_NCTX - 1;
   // Data memory, upper bytes at odd addresses
   logic [7:0] ram_lo [0:`DSACC_RAM_WORDS-1];
   logic [7:0] ram_hi [0:`DSACC_RAM_WORDS-1];
   logic [15:0] wreg_q [0:`DSACC_NCTX-1][0:`DSACC_NWREG-1];
   logic [39:0] dsp_accumulator_a_q [0:`DSACC_NCTX-1];
   logic [39:0] dsp_accumulator_b_q [0:`DSACC_NCTX-1];
   logic [22:0] pc_q;
   logic [22:0] lstart_q;
   logic flag_q;
   logic [15:0] rd_data_q;
   logic rd_valid_q;
   logic [15:0] ram_word_q;
   logic [1:0] rd_src_q;
   logic rd_byte_q;
   logic rd_odd_q;
   logic [15:0] reg_word_q;
   logic [2:0] ctx_q;
   dsacc_pkg::dsacc_fault_t fstate_q;

   function automatic logic [15:0] step(input logic byte_op);
      step = byte_op ? `DSACC_STEP_BYTE : `DSACC_STEP_WORD;
   endfunction

   function automatic logic is_ram(input logic [15:0] a);
      is_ram = !a[`DSACC_WIN_BIT] && a >= `DSACC_RAM_BASE
         && (a - `DSACC_RAM_BASE) < 16'(2 * `DSACC_RAM_WORDS);
   endfunction

   function automatic logic [12:0] ram_idx(input logic [15:0] a);
      logic [15:0] off;
      off = a - `DSACC_RAM_BASE;
      ram_idx = off[13:1];
   endfunction

   // Context 0 is primary; W15 is shared across contexts
   function automatic logic [2:0] ctx_of(input logic [3:0] r, input logic [2:0] c);
      ctx_of = (r == 4'hf || c > 3'(NALT)) ? 3'h0 : c;
   endfunction

   // Word slot of a mapped accumulator: 0 low, 1 middle, 2 guard byte
   function automatic logic [1:0] acc_slot(input logic [15:0] a, input logic [15:0] base);
      logic [15:0] off;
      off = a - base;
      acc_slot = off[2:1];
   endfunction

   // Merge one mapped write into a 40-bit accumulator lane by lane; guard has no high byte
   function automatic logic [39:0] acc_merge(input logic [39:0] old, input logic [1:0] slot,
      input logic [15:0] word, input logic lo, input logic hi);
      logic [39:0] nxt;
      nxt = old;
      if (slot == 2'h0 && lo)
         nxt[7:0] = word[7:0];
      if (slot == 2'h0 && hi)
         nxt[15:8] = word[15:8];
      if (slot == 2'h1 && lo)
         nxt[23:16] = word[7:0];
      if (slot == 2'h1 && hi)
         nxt[31:24] = word[15:8];
      if (slot == 2'h2 && lo)
         nxt[39:32] = word[7:0];
      acc_merge = nxt;
   endfunction

   // Read path decode, own address generator
   wire [15:0] rd_ea = rd_near ? {3'h0, rd_near_addr} : rd_addr;
   wire rd_mis = rd_en && !rd_byte && rd_ea[0];
   wire rd_is_ram = is_ram(rd_ea);
   wire rd_is_sfr = rd_ea <= `DSACC_SFR_LAST;
   wire [3:0] rd_wsel = rd_ea[4:1];
   wire rd_is_w = rd_is_sfr && rd_ea < `DSACC_DSP_ACCUMULATOR_A_BASE;
   // Write path decode, independent of the read path
   wire wr_mis = wr_en && !wr_byte && wr_addr[0];
   wire wr_go = wr_en && !wr_mis;
   wire wr_is_ram = is_ram(wr_addr);
   wire [12:0] wr_idx = ram_idx(wr_addr);
   wire wr_lane_lo = wr_go && (!wr_byte || !wr_addr[0]);
   wire wr_lane_hi = wr_go && (!wr_byte || wr_addr[0]);
   wire [7:0] wr_hi_byte = wr_byte ? wr_data[7:0] : wr_data[15:8];
   wire wr_is_w = wr_addr < `DSACC_DSP_ACCUMULATOR_A_BASE;
   wire [3:0] wr_wsel = wr_addr[4:1];
   wire [2:0] wr_ctx = ctx_of(wr_wsel, ctx_q);
   wire [2:0] rd_ctx = ctx_of(rd_wsel, ctx_q);
   wire [2:0] ld_ctx = ctx_of(wreg_sel, ctx_q);
   wire [15:0] ld_old = wreg_q[ld_ctx][wreg_sel];
   wire [2:0] ac = ctx_q > 3'(NALT) ? 3'h0 : ctx_q;
   wire mis_any = rd_mis || wr_mis;
   // Mapped accumulator writes in the active context; a core load in the same cycle wins
   wire wr_acc_a = wr_addr >= `DSACC_DSP_ACCUMULATOR_A_BASE && wr_addr < `DSACC_DSP_ACCUMULATOR_B_BASE;
   wire wr_acc_b = wr_addr >= `DSACC_DSP_ACCUMULATOR_B_BASE && wr_addr < `DSACC_PC_LO;
   wire [15:0] wr_word = {wr_hi_byte, wr_data[7:0]};
   wire [1:0] dsp_accumulator_a_slot = acc_slot(wr_addr, `DSACC_DSP_ACCUMULATOR_A_BASE);
   wire [1:0] dsp_accumulator_b_slot = acc_slot(wr_addr, `DSACC_DSP_ACCUMULATOR_B_BASE);
   wire [39:0] dsp_accumulator_a_wr = acc_merge(dsp_accumulator_a_q[ac], dsp_accumulator_a_slot, wr_word, wr_lane_lo, wr_lane_hi);
   wire [39:0] dsp_accumulator_b_wr = acc_merge(dsp_accumulator_b_q[ac], dsp_accumulator_b_slot, wr_word, wr_lane_lo, wr_lane_hi);

   // Mapped core register read mux; unused addresses give zero
   logic [15:0] reg_word;
   always_comb
   begin
      reg_word = `DSACC_ZERO16;
      if (rd_is_w)
         reg_word = wreg_q[rd_ctx][rd_wsel];
      else if (rd_ea == `DSACC_DSP_ACCUMULATOR_A_BASE)
         reg_word = dsp_accumulator_a_q[ac][15:0];
      else if (rd_ea == `DSACC_DSP_ACCUMULATOR_A_BASE + 16'h2)
         reg_word = dsp_accumulator_a_q[ac][31:16];
      else if (rd_ea == `DSACC_DSP_ACCUMULATOR_A_BASE + 16'h4)
         reg_word = {8'h00, dsp_accumulator_a_q[ac][39:32]};
      else if (rd_ea == `DSACC_DSP_ACCUMULATOR_B_BASE)
         reg_word = dsp_accumulator_b_q[ac][15:0];
      else if (rd_ea == `DSACC_DSP_ACCUMULATOR_B_BASE + 16'h2)
         reg_word = dsp_accumulator_b_q[ac][31:16];
      else if (rd_ea == `DSACC_DSP_ACCUMULATOR_B_BASE + 16'h4)
         reg_word = {8'h00, dsp_accumulator_b_q[ac][39:32]};
      else if (rd_ea == `DSACC_PC_LO)
         reg_word = pc_q[15:0];
      else if (rd_ea == `DSACC_PC_HI)
         reg_word = {9'h000, pc_q[22:16]};
      else if (rd_ea == `DSACC_LSTART_LO)
         reg_word = lstart_q[15:0];
      else if (rd_ea == `DSACC_LSTART_HI)
         reg_word = {9'h000, lstart_q[22:16]};
      else if (rd_ea == `DSACC_INTERRUPT_CONTROL_ONE)
         reg_word = 16'(flag_q) << `DSACC_ADDRESS_FAULT_FLAG_BIT;
   end

   // Read data steering after the registered fetch
   wire [15:0] word_sel = rd_src_q[0] ? ram_word_q : (rd_src_q[1] ? reg_word_q : `DSACC_ZERO16);
   wire [7:0] byte_sel = rd_odd_q ? word_sel[15:8] : word_sel[7:0];
   wire [15:0] rd_result = rd_byte_q ? {8'h00, byte_sel} : word_sel;
   // Extension applied to the working register byte path
   logic [15:0] ld_val;
   always_comb
   begin
      unique case (wreg_op)
         dsacc_pkg::DSACC_EXT_SIGN: ld_val = {{8{wreg_byte[7]}}, wreg_byte};
         dsacc_pkg::DSACC_EXT_ZERO: ld_val = {8'h00, ld_old[7:0]};
         default: ld_val = {ld_old[15:8], wreg_byte};
      endcase
   end

   // Memory array: whole word fetched every read
   always_ff @(posedge mclk)
   begin
      ram_word_q <= {ram_hi[ram_idx(rd_ea)], ram_lo[ram_idx(rd_ea)]};
      if (wr_is_ram && wr_lane_lo)
         ram_lo[wr_idx] <= wr_data[7:0];
      if (wr_is_ram && wr_lane_hi)
         ram_hi[wr_idx] <= wr_hi_byte;
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         rd_valid_q <= 1'b0;
         rd_data_q <= `DSACC_ZERO16;
         rd_src_q <= 2'b00;
         rd_byte_q <= 1'b0;
         rd_odd_q <= 1'b0;
         reg_word_q <= `DSACC_ZERO16;
      end
      else
      begin
         // Misaligned reads still complete; the trap and the fault flag report them
         rd_valid_q <= rd_en;
         rd_src_q <= {rd_is_sfr && !rd_is_ram, rd_is_ram && !rd_ea[`DSACC_WIN_BIT]};
         rd_byte_q <= rd_byte;
         rd_odd_q <= rd_ea[0];
         reg_word_q <= reg_word;
         if (rd_valid_q)
            rd_data_q <= rd_result;
      end
   end

   // Core register file; the working register byte path wins over a mapped write
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         for (int c = 0; c < `DSACC_NCTX; c++)
         begin
            dsp_accumulator_a_q[c] <= 40'h00_0000_0000;
            dsp_accumulator_b_q[c] <= 40'h00_0000_0000;
            for (int r = 0; r < `DSACC_NWREG; r++)
               wreg_q[c][r] <= `DSACC_ZERO16;
         end
         pc_q <= 23'h00_0000;
         lstart_q <= 23'h00_0000;
         ctx_q <= 3'h0;
      end
      else
      begin
         ctx_q <= ctx_sel;
         pc_q <= pc_in;
         lstart_q <= loop_start_in;
         if (acc_load)
         begin
            dsp_accumulator_a_q[ac] <= acc_a_in;
            dsp_accumulator_b_q[ac] <= acc_b_in;
         end
         else if (wr_acc_a)
            dsp_accumulator_a_q[ac] <= dsp_accumulator_a_wr;
         else if (wr_acc_b)
            dsp_accumulator_b_q[ac] <= dsp_accumulator_b_wr;
         if (wr_is_w && wr_lane_lo)
            wreg_q[wr_ctx][wr_wsel][7:0] <= wr_data[7:0];
         if (wr_is_w && wr_lane_hi)
            wreg_q[wr_ctx][wr_wsel][15:8] <= wr_hi_byte;
         if (wreg_load)
            wreg_q[ld_ctx][wreg_sel] <= ld_val;
      end
   end

   // Fault flag: a new fault in the clear cycle keeps the flag set
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         flag_q <= 1'b0;
         fstate_q <= dsacc_pkg::DSACC_REG_IDLE;
      end
      else
      begin
         if (mis_any)
            flag_q <= 1'b1;
         else if (fault_clear)
            flag_q <= 1'b0;
         unique case (fstate_q)
            dsacc_pkg::DSACC_REG_IDLE:
               if (mis_any)
                  fstate_q <= dsacc_pkg::DSACC_REG_FAULT;
            dsacc_pkg::DSACC_REG_FAULT:
               if (!mis_any)
                  fstate_q <= dsacc_pkg::DSACC_REG_IDLE;
         endcase
      end
   end

   assign rd_data = rd_data_q;
   assign rd_valid = rd_valid_q;
   assign rd_window = rd_en && rd_ea[`DSACC_WIN_BIT];
   assign rd_next_addr = rd_post_inc ? rd_ea + step(rd_byte) : rd_ea;
   assign wr_next_addr = wr_post_inc ? wr_addr + step(wr_byte) : wr_addr;
   assign wreg_rd_data = wreg_q[ld_ctx][wreg_sel];
   assign address_fault_flag = flag_q;
   // Fault state lasts one cycle per misaligned cycle, so it is the trap pulse itself
   assign trap_req = fstate_q == dsacc_pkg::DSACC_REG_FAULT;
   assign pc_out = pc_q;
endmodule // dsacc_top

//--- bench/dsacc_chk.sv
// Port-level assertions for the data-space access block
module dsacc_chk
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic rd_en,
   input wire logic [15:0] rd_addr,
   input wire logic rd_byte,
   input wire logic rd_post_inc,
   input wire logic rd_near,
   input wire logic [12:0] rd_near_addr,
   input wire logic [15:0] rd_data,
   input wire logic rd_valid,
   input wire logic [15:0] rd_next_addr,
   input wire logic rd_window,
   input wire logic wr_en,
   input wire logic [15:0] wr_addr,
   input wire logic wr_byte,
   input wire logic wr_post_inc,
   input wire logic [15:0] wr_next_addr,
   input wire logic [22:0] pc_in,
   input wire logic [22:0] pc_out,
   input wire logic address_fault_flag,
   input wire logic trap_req
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] rd_ea;
   logic mis;
   assign rd_ea = rd_near ? {3'h0, rd_near_addr} : rd_addr;
   assign mis = (rd_en && !rd_byte && rd_ea[0]) || (wr_en && !wr_byte && wr_addr[0]);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   sequence s_trap_flag;
      trap_req ##[0:1] address_fault_flag;
   endsequence
   sequence s_zero_answer;
      rd_window ##2 rd_data == 16'h0000;
   endsequence
   a_rd_answer: assert property (rd_en |=> rd_valid)
      else $error("read got no valid pulse");
   a_trap_fault: assert property (mis |=> s_trap_flag)
      else $error("odd word access without trap and flag");
   a_trap_cause: assert property (trap_req |-> $past(mis))
      else $error("trap without a misaligned access");
   a_step_read: assert property (!rd_near |-> rd_next_addr == rd_addr
      + (rd_post_inc ? (rd_byte ? 16'h0001 : 16'h0002) : 16'h0000))
      else $error("read step wrong");
   a_step_write: assert property (1'b1 |-> wr_next_addr == wr_addr
      + (wr_post_inc ? (wr_byte ? 16'h0001 : 16'h0002) : 16'h0000))
      else $error("write step wrong");
   a_window_zero: assert property (rd_en && !rd_near && rd_addr[15] |-> s_zero_answer)
      else $error("window read not zero");
   a_byte_low: assert property (rd_en && rd_byte |-> ##2 rd_data[15:8] == 8'h00)
      else $error("byte read high lane not zero");
   a_pc_follow: assert property (!$past(rst) |-> pc_out == $past(pc_in))
      else $error("pc_out does not follow pc_in");
   a_data_hold: assert property (!rd_valid |=> $stable(rd_data))
      else $error("read data changed without a read");
endmodule // dsacc_chk
bind dsacc_top dsacc_chk u_chk (.*);

//--- bench/dsacc_agu.sv
// Read and write address generators facing the data-space block
module dsacc_agu
(
   input wire logic mclk,
   input wire logic [15:0] rd_data,
   output logic rd_en,
   output logic [15:0] rd_addr,
   output logic rd_byte,
   output logic rd_post_inc,
   output logic rd_near,
   output logic [12:0] rd_near_addr,
   output logic wr_en,
   output logic [15:0] wr_addr,
   output logic wr_byte,
   output logic wr_post_inc,
   output logic [15:0] wr_data
);
   timeunit 1ns;
   timeprecision 100ps;
   initial
   begin
      {rd_en, rd_byte, rd_post_inc, rd_near, wr_en, wr_byte, wr_post_inc} = 7'h00;
      {rd_addr, rd_near_addr, wr_addr, wr_data} = 61'h0;
   end
   // Odd word addresses come only when a scenario asks for a fault
   // Released lines are inverted so a stale address never looks live
   task automatic rd(input logic [15:0] a, input logic b, input logic n,
      output logic [15:0] d);
      @(posedge mclk);
      {rd_en, rd_byte, rd_near, rd_post_inc, rd_addr} <= {1'b1, b, n, 1'b1, a};
      rd_near_addr <= a[12:0];
      @(posedge mclk);
      {rd_en, rd_post_inc, rd_addr} <= {2'h0, ~a};
      rd_near_addr <= ~a[12:0];
      @(posedge mclk);
      #1 d = rd_data;
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic b);
      @(posedge mclk);
      {wr_en, wr_byte, wr_post_inc, wr_addr, wr_data} <= {1'b1, b, 1'b1, a, d};
      @(posedge mclk);
      {wr_en, wr_post_inc, wr_addr, wr_data} <= {2'h0, ~a, ~d};
   endtask
endmodule // dsacc_agu

//--- bench/data_space_access_tb.sv
// Self-checking bench for the data-space access block
module data_space_access_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk, rst, wreg_load, acc_load, fault_clear;
   logic [3:0] wreg_sel;
   logic [1:0] wreg_op;
   logic [7:0] wreg_byte;
   logic [2:0] ctx_sel;
   logic [22:0] pc_in, loop_start_in, pc_out;
   logic [39:0] acc_a_in, acc_b_in;
   logic rd_en, rd_byte, rd_post_inc, rd_near, rd_valid, rd_window;
   logic wr_en, wr_byte, wr_post_inc, address_fault_flag, trap_req;
   logic [12:0] rd_near_addr;
   logic [15:0] rd_addr, rd_data, rd_next_addr, wr_addr, wr_data, wr_next_addr;
   logic [15:0] wreg_rd_data, d;
   int n_fail = 0;
   int checks = 0;
   int cyc = 0;
   dsacc_top dut (.*);
   dsacc_agu agu (.*);
   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // Whole run needs about 110 cycles; the ceiling at 3000 leaves wide margin
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         n_fail++;
         wrap_up();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic t_ram();
      agu.wr(16'h1000, 16'h1234, 1'b0);
      agu.rd(16'h1000, 1'b0, 1'b0, d);
      chk(d, 16'h1234);
      agu.rd(16'h1001, 1'b1, 1'b0, d);
      chk(d, 16'h0012);
      agu.wr(16'h1001, 16'hffab, 1'b1);
      agu.rd(16'h1000, 1'b0, 1'b0, d);
      chk(d, 16'hab34);
      agu.rd(16'hf000, 1'b0, 1'b1, d);
      chk(d, 16'hab34);
      agu.wr(16'h4ffe, 16'hbeef, 1'b0);
      agu.rd(16'h4ffe, 1'b0, 1'b0, d);
      chk(d, 16'hbeef);
      agu.wr(16'h6000, 16'h5a5a, 1'b0);
      agu.rd(16'h6000, 1'b0, 1'b0, d);
      chk(d, 16'h0000);
      agu.rd(16'h9002, 1'b0, 1'b0, d);
      chk(d, 16'h0000);
      agu.rd(16'h0800, 1'b0, 1'b0, d);
      chk(d, 16'h0000);
   endtask
   task automatic t_mis();
      agu.wr(16'h1002, 16'h1111, 1'b0);
      agu.wr(16'h1003, 16'h5555, 1'b0);
      #1 chk({15'h0, trap_req}, 16'h0001);
      @(posedge mclk);
      #1 chk({15'h0, trap_req}, 16'h0000);
      agu.rd(16'h1002, 1'b0, 1'b0, d);
      chk(d, 16'h1111);
      agu.rd(16'h0036, 1'b0, 1'b0, d);
      chk(d, 16'h0008);
      @(posedge mclk);
      fault_clear <= 1'b1;
      @(posedge mclk);
      fault_clear <= 1'b0;
      #1 chk({15'h0, address_fault_flag}, 16'h0000);
      agu.rd(16'h1005, 1'b0, 1'b0, d);
      chk({15'h0, address_fault_flag}, 16'h0001);
   endtask
   task automatic wop(input logic [1:0] op, input logic [7:0] b, input logic [15:0] e);
      @(posedge mclk);
      {wreg_load, wreg_sel, wreg_op, wreg_byte} <= {1'b1, 4'h3, op, b};
      @(posedge mclk);
      wreg_load <= 1'b0;
      #1 chk(wreg_rd_data, e);
   endtask
   task automatic t_regs();
      agu.wr(16'h0006, 16'ha5c3, 1'b0);
      wop(2'h0, 8'h7e, 16'ha57e);
      wop(2'h1, 8'h80, 16'hff80);
      wop(2'h2, 8'h00, 16'h0080);
      @(posedge mclk);
      ctx_sel <= 3'h1;
      agu.wr(16'h0006, 16'h1111, 1'b0);
      agu.rd(16'h0006, 1'b0, 1'b0, d);
      chk(d, 16'h1111);
      @(posedge mclk);
      ctx_sel <= 3'h0;
      agu.rd(16'h0006, 1'b0, 1'b0, d);
      chk(d, 16'h0080);
      agu.wr(16'h0032, 16'hffff, 1'b0);
      agu.rd(16'h0032, 1'b0, 1'b0, d);
      chk(d, 16'h2345);
      agu.rd(16'h0030, 1'b0, 1'b0, d);
      chk(d, 16'h007a);
      chk(pc_out[15:0], 16'hbcde);
      @(posedge mclk);
      acc_load <= 1'b1;
      @(posedge mclk);
      acc_load <= 1'b0;
      agu.rd(16'h0020, 1'b0, 1'b0, d);
      chk(d, 16'h789a);
      agu.rd(16'h002a, 1'b0, 1'b0, d);
      chk(d, 16'h003c);
      agu.wr(16'h0022, 16'h5555, 1'b0);
      agu.wr(16'h0021, 16'h00c4, 1'b1);
      agu.rd(16'h0022, 1'b0, 1'b0, d);
      chk(d, 16'h5555);
      agu.rd(16'h0020, 1'b0, 1'b0, d);
      chk(d, 16'hc49a);
   endtask
   task automatic t_rst();
      @(posedge mclk);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      #1 chk({15'h0, address_fault_flag}, 16'h0000);
      chk(rd_data, 16'h0000);
   endtask
   task automatic wrap_up();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      rst = 1'b1;
      {wreg_load, acc_load, fault_clear, wreg_sel, wreg_op, wreg_byte, ctx_sel} = 20'h0;
      pc_in = 23'h7abcde;
      loop_start_in = 23'h512345;
      acc_a_in = 40'h123456789a;
      acc_b_in = 40'h3c00000000;
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      t_ram();
      t_mis();
      t_rst();
      t_regs();
      wrap_up();
   end
endmodule // data_space_access_tb
